// ==== cec_pkg.sv ====
// package: register map, field layout and constants of the comparator event control
package cec_pkg;
  // ==========================================
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h04;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h08;
  localparam logic [7:0] CHAN_AVAIL_OFS = 8'h0C;
  // ==========================================
  // control register fields
  localparam int ON_BIT = 15;
  localparam int OE_BIT = 14;
  localparam int INV_BIT = 13;
  localparam int EVT_BIT = 9;
  localparam int OUT_BIT = 8;
  localparam int EDGE_HI = 7;
  localparam int EDGE_LO = 6;
  localparam int REF_BIT = 4;
  localparam int CH_HI = 1;
  localparam int CH_LO = 0;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] CTRL_WMASK = 16'hE2D3;
  // ==========================================
  // edge selection codes
  typedef enum logic [1:0] {
    EDGE_OFF = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_BOTH = 2'b11
  } cec_edge_t;
  // ==========================================
  // interrupt status bits and channel availability reset value
  localparam int IRQ_EVT = 0;
  localparam int IRQ_NOCH = 1;
  localparam int IRQ_W = 2;
  localparam logic [3:0] CHAN_AVAIL_RST = 4'hF;
endpackage

// ==== cec_sync.sv ====
// two-flop synchroniser for the asynchronous comparator result
module cec_sync
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // raw level and result
  input wire logic asyncIn,
  output logic syncOut
);
  logic meta_q;
  logic sync_q;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      meta_q <= asyncIn;
      sync_q <= meta_q;
    end
  end

  assign syncOut = sync_q;
endmodule // cec_sync

// ==== cec_comparator_event_control.sv ====
// comparator event control: control register, event logic and APB slave
// Behaviour
// [RULE1] event flag sets on an output edge matching edge selection and polarity
// [RULE2] while event flag is set, further triggers and interrupts are suppressed (the IRQ_NOCH status bit still sets and can raise irq)
// [RULE3] non-inverted: status reads 1 when plus input exceeds minus input
// [RULE4] inverted: status reads 1 when plus input is below minus input
// [RULE5] edge select 10 falling only, 01 rising only, 00 disabled
// [RULE6] a selected but absent channel drives the minus input to ground
// [RULE7] with comparator off, no events, triggers or interrupts occur
module cec_comparator_event_control
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // analogue comparator raw result (plus above minus) and input mux
  input wire logic cmpRaw,
  output logic [1:0] inputChannelSelect,
  output logic referenceSelect,
  output logic minusToGround,
  output logic comparatorOn,
  // output pin and events
  output logic comparatorOutputPin,
  output logic comparatorOutputPinOe,
  output logic trigger,
  output logic irq
);
  // ==========================================
  // state
  logic [15:0] ctrl_q;
  logic [cec_pkg::IRQ_W-1:0] stat_q;
  logic [cec_pkg::IRQ_W-1:0] mask_q;
  logic [3:0] avail_q;
  logic out_q;
  logic outPrev_q;
  logic trig_q;
  logic cmpSync;

  cec_sync u_sync
  (
    .mclk(mclk),
    .rst(rst),
    .asyncIn(cmpRaw),
    .syncOut(cmpSync)
  );

  // ==========================================
  // control decode
  wire enOn = ctrl_q[cec_pkg::ON_BIT];
  wire outInv = ctrl_q[cec_pkg::INV_BIT];
  wire eventFlag = ctrl_q[cec_pkg::EVT_BIT];
  wire [1:0] edgeSel = ctrl_q[cec_pkg::EDGE_HI:cec_pkg::EDGE_LO];
  wire [1:0] chanSel = ctrl_q[cec_pkg::CH_HI:cec_pkg::CH_LO];
  wire chanMissing = ~avail_q[chanSel];
  // polarity-adjusted comparator result
  wire adjOut = cmpSync ^ outInv; // RULE3 RULE4
  wire rise = adjOut & ~outPrev_q;
  wire fall = ~adjOut & outPrev_q;
  wire edgeHit = (edgeSel == cec_pkg::EDGE_RISE && rise) ||
    (edgeSel == cec_pkg::EDGE_FALL && fall) ||
    (edgeSel == cec_pkg::EDGE_BOTH && (rise || fall)); // RULE5
  wire evtFire = enOn && !eventFlag && edgeHit; // RULE1 RULE2 RULE7

  // ==========================================
  // apb decode
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire hitCtrl = paddr == cec_pkg::CTRL_OFS;
  wire hitStat = paddr == cec_pkg::IRQ_STAT_OFS;
  wire hitMask = paddr == cec_pkg::IRQ_MASK_OFS;
  wire hitAvail = paddr == cec_pkg::CHAN_AVAIL_OFS;
  wire mapped = hitCtrl | hitStat | hitMask | hitAvail;
  wire wrCtrl = wr && hitCtrl;
  wire [15:0] ctrlW = (pwdata[15:0] & cec_pkg::CTRL_WMASK) | (ctrl_q & ~cec_pkg::CTRL_WMASK);
  wire [cec_pkg::IRQ_W-1:0] statSet = {enOn && chanMissing, evtFire};
  wire [cec_pkg::IRQ_W-1:0] statClr = (wr && hitStat) ? pwdata[cec_pkg::IRQ_W-1:0] : '0;

  assign pready = 1'b1;
  assign pslverr = acc && !mapped;

  // ==========================================
  // registers
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ctrl_q <= cec_pkg::CTRL_RST;
      stat_q <= '0;
      mask_q <= '0;
      avail_q <= cec_pkg::CHAN_AVAIL_RST;
      out_q <= 1'b0;
      outPrev_q <= 1'b0;
      trig_q <= 1'b0;
    end
    else
    begin
      if (wrCtrl)
        ctrl_q <= ctrlW;
      // event set wins over a software clear
      if (evtFire)
        ctrl_q[cec_pkg::EVT_BIT] <= 1'b1; // RULE1
      ctrl_q[cec_pkg::OUT_BIT] <= enOn ? adjOut : 1'b0;
      stat_q <= (stat_q & ~statClr) | statSet;
      if (wr && hitMask)
        mask_q <= pwdata[cec_pkg::IRQ_W-1:0];
      if (wr && hitAvail)
        avail_q <= pwdata[3:0];
      out_q <= enOn ? adjOut : 1'b0;
      outPrev_q <= adjOut;
      trig_q <= evtFire; // RULE2
    end
  end

  // ==========================================
  // outputs
  always_comb
  begin
    prdata = 32'h0000_0000;
    if (hitCtrl)
      prdata[15:0] = ctrl_q;
    else if (hitStat)
      prdata[cec_pkg::IRQ_W-1:0] = stat_q;
    else if (hitMask)
      prdata[cec_pkg::IRQ_W-1:0] = mask_q;
    else if (hitAvail)
      prdata[3:0] = avail_q;
  end

  assign inputChannelSelect = chanSel;
  assign referenceSelect = ctrl_q[cec_pkg::REF_BIT];
  assign minusToGround = chanMissing; // RULE6
  assign comparatorOn = enOn;
  assign comparatorOutputPin = out_q;
  assign comparatorOutputPinOe = enOn && ctrl_q[cec_pkg::OE_BIT];
  assign trigger = trig_q;
  assign irq = |(stat_q & mask_q);

  // ==========================================
  // assertions
  property p_evtSet;
    @(posedge mclk) disable iff (rst)
    evtFire |=> ctrl_q[cec_pkg::EVT_BIT] && trigger;
  endproperty
  a_evtSet: assert property (p_evtSet) else $error("event flag not set"); // RULE1

  property p_lockout;
    @(posedge mclk) disable iff (rst)
    ctrl_q[cec_pkg::EVT_BIT] && !(wrCtrl && !pwdata[cec_pkg::EVT_BIT]) |=> !trigger;
  endproperty
  a_lockout: assert property (p_lockout) else $error("trigger while flag set"); // RULE2

  property p_noninv;
    @(posedge mclk) disable iff (rst)
    enOn && !outInv && $stable(outInv) && $stable(enOn) |=> ctrl_q[cec_pkg::OUT_BIT] == $past(cmpSync);
  endproperty
  a_noninv: assert property (p_noninv) else $error("status wrong non-inverted"); // RULE3

  property p_inv;
    @(posedge mclk) disable iff (rst)
    enOn && outInv && $stable(outInv) && $stable(enOn) |=> ctrl_q[cec_pkg::OUT_BIT] == !$past(cmpSync);
  endproperty
  a_inv: assert property (p_inv) else $error("status wrong inverted"); // RULE4

  property p_edgeOff;
    @(posedge mclk) disable iff (rst)
    edgeSel == cec_pkg::EDGE_OFF |=> !trigger;
  endproperty
  a_edgeOff: assert property (p_edgeOff) else $error("trigger with edges off"); // RULE5

  property p_riseOnly;
    @(posedge mclk) disable iff (rst)
    edgeSel == cec_pkg::EDGE_RISE && fall |=> !trigger;
  endproperty
  a_riseOnly: assert property (p_riseOnly) else $error("trigger on wrong edge"); // RULE5

  property p_ground;
    @(posedge mclk) disable iff (rst)
    !avail_q[chanSel] |-> minusToGround;
  endproperty
  a_ground: assert property (p_ground) else $error("absent input not grounded"); // RULE6

  property p_off;
    @(posedge mclk) disable iff (rst)
    !enOn |=> !trigger;
  endproperty
  a_off: assert property (p_off) else $error("trigger while off"); // RULE7

  property p_trigPulse;
    @(posedge mclk) disable iff (rst)
    trigger |=> !trigger;
  endproperty
  a_trigPulse: assert property (p_trigPulse) else $error("trigger longer than one cycle"); // RULE2

  property p_pinOff;
    @(posedge mclk) disable iff (rst)
    !enOn |=> !comparatorOutputPin && !ctrl_q[cec_pkg::OUT_BIT];
  endproperty
  a_pinOff: assert property (p_pinOff) else $error("output active while off"); // RULE7

  property p_fallOnly;
    @(posedge mclk) disable iff (rst)
    edgeSel == cec_pkg::EDGE_FALL && rise |=> !trigger;
  endproperty
  a_fallOnly: assert property (p_fallOnly) else $error("trigger on rise in fall mode"); // RULE5

  c_lock: cover property (@(posedge mclk) disable iff (rst) eventFlag && edgeHit && enOn);
  c_ground: cover property (@(posedge mclk) disable iff (rst) minusToGround);

  c_event: cover property (@(posedge mclk) disable iff (rst) trigger);
  c_irq: cover property (@(posedge mclk) disable iff (rst) $rose(irq));
  c_fall: cover property (@(posedge mclk) disable iff (rst) edgeSel == cec_pkg::EDGE_FALL && trigger);
endmodule // cec_comparator_event_control

// ==== cec_tb.sv ====
// self-checking bench of the comparator event control over apb
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst, psel, penable, pwrite, cmpRaw;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, minusToGround, comparatorOn, referenceSelect;
  logic comparatorOutputPin, comparatorOutputPinOe, trigger, irq;
  logic [1:0] inputChannelSelect, ch;
  int mismatches, n_tests, trigs;
  logic [31:0] expQ[$];
  // ==========================================
  // device under test
  cec_comparator_event_control dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmpRaw(cmpRaw), .inputChannelSelect(inputChannelSelect),
    .referenceSelect(referenceSelect), .minusToGround(minusToGround),
    .comparatorOn(comparatorOn), .comparatorOutputPin(comparatorOutputPin),
    .comparatorOutputPinOe(comparatorOutputPinOe), .trigger(trigger), .irq(irq));
  initial
  begin
    mclk = 0;
    forever #12.5 mclk = ~mclk;
  end
  // ==========================================
  // checking and closing
  task automatic chk(string name, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // read results taken off the queue as they appear
  always @(posedge mclk)
  begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0)
      chk("prdata", expQ.pop_front(), prdata);
    if (trigger === 1'b1)
      trigs++;
  end
  // ==========================================
  // apb master and stimulus helpers
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d, logic err = 1'b0);
    int n;
    if (!w)
      expQ.push_back(d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= w ? d : 32'h0000_0000;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk("pslverr", {31'h0, err}, {31'h0, pslverr});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic raw(logic v);
    cmpRaw <= v;
    repeat (8) @(posedge mclk);
  endtask
  initial
  begin
    #125000;
    mismatches++;
    end_sim();
  end
  // ==========================================
  // main sequence
  initial
  begin
    {rst, psel, penable, pwrite, cmpRaw} = 5'b10000;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    void'($urandom(47319));
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    apb(0, 8'h00, 32'h0000_0000);
    apb(0, 8'h0C, 32'h0000_000F);
    apb(0, 8'h10, 32'h0000_0000, 1'b1);
    apb(1, 8'h08, 32'h0000_0001);
    apb(1, 8'h00, 32'h0000_C000);
    raw(1);
    apb(0, 8'h00, 32'h0000_C100);
    chk("pin", 32'h1, {31'h0, comparatorOutputPin & comparatorOutputPinOe});
    chk("on", 32'h1, {31'h0, comparatorOn});
    apb(1, 8'h00, 32'h0000_A000);
    apb(0, 8'h00, 32'h0000_A000);
    raw(0);
    apb(0, 8'h00, 32'h0000_A100);
    apb(1, 8'h00, 32'h0000_8000);
    raw(1);
    raw(0);
    chk("trigs off edge", 32'h0, trigs);
    apb(1, 8'h00, 32'h0000_8040);
    raw(1);
    chk("trigs rise", 32'h1, trigs);
    apb(0, 8'h00, 32'h0000_8340);
    chk("irq", 32'h1, {31'h0, irq});
    raw(0);
    raw(1);
    chk("trigs locked", 32'h1, trigs);
    apb(1, 8'h04, 32'h0000_0001);
    raw(0);
    chk("irq locked", 32'h0, {31'h0, irq});
    apb(1, 8'h00, 32'h0000_8080);
    raw(1);
    chk("trigs rise ignored", 32'h1, trigs);
    raw(0);
    chk("trigs fall", 32'h2, trigs);
    apb(0, 8'h00, 32'h0000_8280);
    apb(1, 8'h04, 32'h0000_0001);
    apb(1, 8'h00, 32'h0000_00C0);
    raw(1);
    raw(0);
    chk("trigs off", 32'h2, trigs);
    chk("irq off", 32'h0, {31'h0, irq});
    ch = 2'($urandom());
    apb(1, 8'h0C, {28'h0, ~(4'h1 << ch)});
    apb(1, 8'h00, {27'h0, 1'b1, 2'b00, ch});
    chk("ground", 32'h1, {31'h0, minusToGround});
    chk("channel", {30'h0, ch}, {30'h0, inputChannelSelect});
    chk("reference", 32'h1, {31'h0, referenceSelect});
    chk("on cleared", 32'h0, {31'h0, comparatorOn});
    chk("oe cleared", 32'h0, {31'h0, comparatorOutputPinOe});
    apb(1, 8'h0C, 32'h0000_000F);
    chk("no ground", 32'h0, {31'h0, minusToGround});
    repeat (4) @(posedge mclk);
    end_sim();
  end
endmodule // tb
